// File: src/serial_port.sv
`default_nettype none
// Function
// - Handshake mode: full DMA buffer raises RTS.
// - Writing force-high command drives RTS high.
// - Writing force-low command drives RTS low, unless force-high or a handshake buffer-full edge comes in the same cycle.
// - T1 receive restored by soft reset, rewrite.
// - SPI slave: extra bits flag an error.
module serial_port
  import serial_port_pkg::*;
#(
  parameter int char_len = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic link_clk,
  input wire logic link_data,
  input wire logic link_sel_n,
  input wire logic dma_buf_full,
  output logic rts,
  output logic irq
);
  typedef struct packed {
    logic [2:0] clk_sync;
    logic [1:0] dat_sync;
    logic [1:0] sel_sync;
    logic [1:0] full_sync;
    logic full_prev;
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [3:0] mode;
    logic [ev_width-1:0] status;
    logic [ev_width-1:0] mask;
    logic rx_blocked;
    logic [char_len-1:0] shift;
    logic [7:0] bit_cnt;
    logic [char_len-1:0] rx_data;
    logic rts;
    logic irq;
  } state_t;
  state_t state_reg, state_next;
  logic wr_fire, rd_fire, link_rise, frame_end;
  logic [ev_width-1:0] ev_set, ev_clr;
  logic [31:0] wmask;
  function automatic logic [31:0] strb_mask(input logic [3:0] s);
    strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction
  always_comb begin
    state_next = state_reg;
    // Second stage alone feeds logic; the third stage is the edge history.
    state_next.clk_sync = {state_reg.clk_sync[1:0], link_clk};
    state_next.dat_sync = {state_reg.dat_sync[0], link_data};
    state_next.sel_sync = {state_reg.sel_sync[0], link_sel_n};
    state_next.full_sync = {state_reg.full_sync[0], dma_buf_full};
    state_next.full_prev = state_reg.full_sync[1];
    link_rise = state_reg.clk_sync[1] & ~state_reg.clk_sync[2];
    frame_end = state_reg.sel_sync[1] & (state_reg.bit_cnt != 8'h00);
    ev_set = '0;
    ev_clr = '0;
    wmask = strb_mask(s_axi_wstrb);
    if (s_axi_awvalid && s_axi_awready) begin
      state_next.aw_got = 1'b1;
      state_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      state_next.w_got = 1'b1;
      state_next.w_data = s_axi_wdata & wmask;
    end
    wr_fire = state_reg.aw_got && state_reg.w_got && !state_reg.bvalid;
    if (wr_fire) begin
      state_next.aw_got = 1'b0;
      state_next.w_got = 1'b0;
      state_next.bvalid = 1'b1;
      state_next.bresp = resp_okay;
      case ({state_reg.aw_addr[7:2], 2'b00})
        ctrl_off: begin
          // Command bits are strobes; zeros change nothing.
          if (state_reg.w_data[rts_high_bit]) begin
            state_next.rts = 1'b1;
          end else if (state_reg.w_data[rts_low_bit]) begin
            state_next.rts = 1'b0;
          end
          if (state_reg.w_data[rx_reset_bit]) begin
            state_next.shift = '0;
            state_next.bit_cnt = 8'h00;
            state_next.rx_blocked = 1'b0;
          end
        end
        mode_off: begin
          state_next.mode = state_reg.w_data[3:0];
          state_next.rx_blocked = 1'b0;
        end
        stat_off: ev_clr = state_reg.w_data[ev_width-1:0];
        mask_off: state_next.mask = state_reg.w_data[ev_width-1:0];
        default: state_next.bresp = resp_slverr;
      endcase
    end
    if (state_reg.bvalid && s_axi_bready) begin
      state_next.bvalid = 1'b0;
    end
    rd_fire = s_axi_arvalid && state_reg.arready;
    state_next.arready = !state_reg.rvalid && !rd_fire;
    if (rd_fire) begin
      state_next.arready = 1'b0;
      state_next.rvalid = 1'b1;
      state_next.rresp = resp_okay;
      state_next.rdata = '0;
      case ({s_axi_araddr[7:2], 2'b00})
        ctrl_off: state_next.rdata = '0;
        mode_off: state_next.rdata = {28'h0, state_reg.mode};
        stat_off: state_next.rdata = {{(32-ev_width){1'b0}}, state_reg.status};
        mask_off: state_next.rdata = {{(32-ev_width){1'b0}}, state_reg.mask};
        rxd_off: state_next.rdata = 32'(state_reg.rx_data);
        dmab_off: state_next.rdata = {30'h0, state_reg.rts, state_reg.full_sync[1]};
        default: state_next.rresp = resp_slverr;
      endcase
    end
    if (state_reg.rvalid && s_axi_rready) begin
      state_next.rvalid = 1'b0;
    end
    if (state_reg.mode[mode_hand_bit] && state_reg.full_sync[1] && !state_reg.full_prev) begin
      state_next.rts = 1'b1;
      ev_set[ev_buf_full] = 1'b1;
    end
    // Bits are taken on link rising edges; the peer keeps the link slow.
    if (state_reg.mode[mode_rx_en_bit] && !state_reg.rx_blocked) begin
      if (!state_reg.sel_sync[1] && link_rise) begin
        state_next.shift = {state_reg.shift[char_len-2:0], state_reg.dat_sync[1]};
        if (state_reg.bit_cnt != 8'hff) begin
          state_next.bit_cnt = state_reg.bit_cnt + 8'h01;
        end
        if (!state_reg.mode[mode_spi_bit] && state_reg.bit_cnt == 8'(char_len - 1)) begin
          state_next.rx_data = {state_reg.shift[char_len-2:0], state_reg.dat_sync[1]};
          state_next.bit_cnt = 8'h00;
          ev_set[ev_rx_ready] = 1'b1;
        end
      end
      if (state_reg.mode[mode_spi_bit] && frame_end) begin
        state_next.bit_cnt = 8'h00;
        if (state_reg.bit_cnt > 8'(char_len)) begin
          ev_set[ev_overlen] = 1'b1;
        end else begin
          state_next.rx_data = state_reg.shift;
          ev_set[ev_rx_ready] = 1'b1;
        end
      end
    end
    // A T1 character taken blocks reception until the reset sequence.
    if (state_reg.mode[mode_iso_t1_bit] && ev_set[ev_rx_ready]) begin
      state_next.rx_blocked = 1'b1;
    end
    state_next.status = (state_reg.status & ~ev_clr) | ev_set;
    state_next.irq = |(state_next.status & state_reg.mask);
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end
  assign s_axi_awready = !state_reg.aw_got;
  assign s_axi_wready = !state_reg.w_got;
  assign s_axi_bvalid = state_reg.bvalid;
  assign s_axi_bresp = state_reg.bresp;
  assign s_axi_arready = state_reg.arready;
  assign s_axi_rvalid = state_reg.rvalid;
  assign s_axi_rdata = state_reg.rdata;
  assign s_axi_rresp = state_reg.rresp;
  assign rts = state_reg.rts;
  assign irq = state_reg.irq;

  // Views of the registered state used only by the checks below.
  // They add no storage and keep the properties readable.
  logic rvalid_q;
  logic status_overlen;
  logic irq_if_masked;
  logic full_edge;
  logic ctrl_write;
  assign rvalid_q = state_reg.rvalid;
  assign status_overlen = state_reg.status[ev_overlen];
  assign irq_if_masked = irq || !state_reg.mask[ev_overlen] || !state_reg.status[ev_overlen];
  assign full_edge = state_reg.mode[mode_hand_bit] && state_reg.full_sync[1] && !state_reg.full_prev;
  assign ctrl_write = wr_fire && state_reg.aw_addr[7:2] == ctrl_off[7:2];

  chk_full_raises_rts: assert property (@(posedge clk) disable iff (rst)
    (state_reg.mode[mode_hand_bit] && state_reg.full_sync[1] && !state_reg.full_prev)
    |=> rts)
    else $error("rts not raised on buffer full");
  chk_force_high: assert property (@(posedge clk) disable iff (rst)
    (wr_fire && state_reg.aw_addr[7:2] == ctrl_off[7:2] && state_reg.w_data[rts_high_bit])
    |=> rts)
    else $error("rts not forced high");
  chk_force_low: assert property (@(posedge clk) disable iff (rst)
    (wr_fire && state_reg.aw_addr[7:2] == ctrl_off[7:2] && state_reg.w_data[rts_low_bit]
     && !state_reg.w_data[rts_high_bit]
     && !(state_reg.mode[mode_hand_bit] && state_reg.full_sync[1] && !state_reg.full_prev))
    |=> !rts)
    else $error("rts not forced low");
  chk_rts_stable: assert property (@(posedge clk) disable iff (rst)
    (!(wr_fire && state_reg.aw_addr[7:2] == ctrl_off[7:2])
     && !(state_reg.mode[mode_hand_bit] && state_reg.full_sync[1] && !state_reg.full_prev))
    |=> $stable(rts))
    else $error("rts changed without a command");
  chk_ctrl_reads_zero: assert property (@(posedge clk) disable iff (rst)
    (rd_fire && s_axi_araddr[7:2] == ctrl_off[7:2]) |=> (rvalid_q && s_axi_rdata == 32'h0))
    else $error("control register read not zero");
  chk_rx_reenable: assert property (@(posedge clk) disable iff (rst)
    (wr_fire && state_reg.aw_addr[7:2] == mode_off[7:2]) |=> !state_reg.rx_blocked)
    else $error("receiver still blocked after mode rewrite");
  chk_overlen_flag: assert property (@(posedge clk) disable iff (rst)
    (state_reg.mode[mode_spi_bit] && state_reg.mode[mode_rx_en_bit] && !state_reg.rx_blocked
     && frame_end && state_reg.bit_cnt > 8'(char_len)) |=> status_overlen ##2 irq_if_masked)
    else $error("overlength frame not flagged");
  chk_irq_level: assert property (@(posedge clk) disable iff (rst)
    1'b1 |=> (irq == $past(|(state_next.status & state_reg.mask))))
    else $error("irq not following masked status");
  chk_irq_masked: assert property (@(posedge clk) disable iff (rst)
    (state_reg.mask == '0) |=> !irq)
    else $error("irq raised with every source masked");
  chk_full_status: assert property (@(posedge clk) disable iff (rst)
    full_edge |=> state_reg.status[ev_buf_full])
    else $error("buffer full event not recorded");
  chk_set_wins: assert property (@(posedge clk) disable iff (rst)
    (wr_fire && state_reg.aw_addr[7:2] == stat_off[7:2] && ev_set[ev_overlen])
    |=> state_reg.status[ev_overlen])
    else $error("status clear beat a new event");

  // Bus answers stand until taken; a master may stall them for any time.
  sequence both_halves_s;
    state_reg.aw_got && state_reg.w_got && !state_reg.bvalid;
  endsequence
  sequence read_taken_s;
    s_axi_arvalid && s_axi_arready;
  endsequence
  chk_write_answer: assert property (@(posedge clk) disable iff (rst)
    both_halves_s |=> s_axi_bvalid)
    else $error("write answer missing");
  chk_bvalid_holds: assert property (@(posedge clk) disable iff (rst)
    (s_axi_bvalid && !s_axi_bready) |=> (s_axi_bvalid && $stable(s_axi_bresp)))
    else $error("write answer dropped before taken");
  chk_read_answer: assert property (@(posedge clk) disable iff (rst)
    read_taken_s |=> s_axi_rvalid)
    else $error("read answer missing");
  chk_rvalid_holds: assert property (@(posedge clk) disable iff (rst)
    (s_axi_rvalid && !s_axi_rready) |=> (s_axi_rvalid && $stable(s_axi_rdata)))
    else $error("read answer dropped before taken");
  chk_aw_held: assert property (@(posedge clk) disable iff (rst)
    state_reg.aw_got |-> !s_axi_awready)
    else $error("address accepted while one is held");
  chk_arready_idle: assert property (@(posedge clk) disable iff (rst)
    s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while an answer stands");

  // A T1 character locks the receiver; a soft reset or a mode write frees it.
  sequence t1_char_s;
    state_reg.mode[mode_iso_t1_bit] && ev_set[ev_rx_ready];
  endsequence
  chk_t1_blocks: assert property (@(posedge clk) disable iff (rst)
    t1_char_s |=> state_reg.rx_blocked)
    else $error("receiver not locked after T1 character");
  chk_blocked_quiet: assert property (@(posedge clk) disable iff (rst)
    state_reg.rx_blocked |=> $stable(state_reg.rx_data))
    else $error("received data changed while locked");
  chk_rx_reset_frees: assert property (@(posedge clk) disable iff (rst)
    (ctrl_write && state_reg.w_data[rx_reset_bit] && !ev_set[ev_rx_ready])
    |=> !state_reg.rx_blocked)
    else $error("receiver still locked after soft reset");

  // A frame of legal length is delivered as a character.
  sequence spi_frame_ok_s;
    state_reg.mode[mode_spi_bit] && state_reg.mode[mode_rx_en_bit] && !state_reg.rx_blocked
    && frame_end && state_reg.bit_cnt <= 8'(char_len);
  endsequence
  chk_spi_char_ok: assert property (@(posedge clk) disable iff (rst)
    spi_frame_ok_s |=> (state_reg.status[ev_rx_ready] && state_reg.rx_data == $past(state_reg.shift)))
    else $error("legal frame not delivered");
endmodule // serial_port
`default_nettype wire

// File: src/serial_port_pkg.sv
`default_nettype none
package serial_port_pkg;
  localparam logic [7:0] ctrl_off = 8'h00;
  localparam logic [7:0] mode_off = 8'h04;
  localparam logic [7:0] stat_off = 8'h08;
  localparam logic [7:0] mask_off = 8'h0c;
  localparam logic [7:0] rxd_off = 8'h10;
  localparam logic [7:0] dmab_off = 8'h14;
  localparam int rx_reset_bit = 0;
  localparam int rts_low_bit = 1;
  localparam int rts_high_bit = 2;
  localparam int mode_hand_bit = 0;
  localparam int mode_spi_bit = 1;
  localparam int mode_iso_t1_bit = 2;
  localparam int mode_rx_en_bit = 3;
  localparam int ev_rx_ready = 0;
  localparam int ev_overlen = 1;
  localparam int ev_buf_full = 2;
  localparam int ev_width = 3;
  localparam int link_ratio_min = 9;
  localparam logic [1:0] resp_okay = 2'b00;
  localparam logic [1:0] resp_slverr = 2'b10;
endpackage
`default_nettype wire

// File: verif/link_peer.sv
`default_nettype none
module link_peer (
  output logic link_clk,
  output logic link_data,
  output logic link_sel_n
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    link_clk = 1'b0;
    link_data = 1'b0;
    link_sel_n = 1'b1;
  end
  // A 200 ns period gives eight core samples per link cycle; the receiver needs four a phase.
  // The clock stands still between frames, and data is inverted once its hold ends.
  task automatic send(input logic [15:0] v, input int n);
    link_sel_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      link_data = v[i];
      #100 link_clk = 1'b1;
      #100 link_clk = 1'b0;
    end
    link_data = ~link_data;
    #200 link_sel_n = 1'b1;
    #400;
  endtask
endmodule // link_peer
`default_nettype wire

// File: verif/testbench.sv
`default_nettype none
module testbench import serial_port_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rst = 1'b1, awv = 1'b0, wv = 1'b0, bvr = 1'b0, arv = 1'b0, rr = 1'b0;
  logic full = 1'b0, awr, wr_rdy, bv, arr, rv, rts, irq, lclk, ldat, lsel_n;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rd;
  logic [1:0] br, rrsp;
  int num_errors = 0;
  int check_count = 0;
  serial_port dut_u (.clk(clk), .rst(rst), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
    .s_axi_wready(wr_rdy), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bvr),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
    .s_axi_rresp(rrsp), .s_axi_rvalid(rv), .s_axi_rready(rr), .link_clk(lclk),
    .link_data(ldat), .link_sel_n(lsel_n), .dma_buf_full(full), .rts(rts), .irq(irq));
  link_peer peer_u (.link_clk(lclk), .link_data(ldat), .link_sel_n(lsel_n));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic summarize();
    $display("checks %0d, mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask
  // Handshakes are judged at the falling edge so no race with the slave's flops arises.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic [1:0] r);
    logic ta, tw, td;
    @(posedge clk);
    awv <= w;
    wv <= w;
    bvr <= w;
    arv <= !w;
    rr <= !w;
    awa <= a;
    ara <= a;
    wd <= d;
    td = 1'b0;
    for (int n = 0; n < 100 && !td; n++) begin
      @(negedge clk);
      ta = (awv & awr) | (arv & arr);
      tw = wv & wr_rdy;
      td = (bvr & bv) | (rr & rv);
      q = rd;
      r = w ? br : rrsp;
      @(posedge clk);
      if (ta) begin
        awv <= 1'b0;
        arv <= 1'b0;
      end
      if (tw) wv <= 1'b0;
    end
    bvr <= 1'b0;
    rr <= 1'b0;
    if (!td) begin
      num_errors++;
      summarize();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic [31:0] q;
    logic [1:0] r;
    bus(1'b1, a, d, q, r);
    chk("write response", {30'h0, er}, {30'h0, r});
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e,
                     input logic [1:0] er);
    logic [31:0] q;
    logic [1:0] r;
    bus(1'b0, a, 32'h0, q, r);
    if (er === resp_okay) chk(nm, e, q);
    chk("read response", {30'h0, er}, {30'h0, r});
  endtask
  task automatic see(input string nm, ref logic s, input logic e);
    for (int n = 0; n < 20 && s !== e; n++) @(negedge clk);
    chk(nm, {31'h0, e}, {31'h0, s});
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    rdc("control", ctrl_off, 32'h0, resp_okay);
    see("rts", rts, 1'b0);
    wr(ctrl_off, 32'h4, resp_okay);
    see("rts", rts, 1'b1);
    wr(ctrl_off, 32'h0, resp_okay);
    see("rts", rts, 1'b1);
    rdc("control", ctrl_off, 32'h0, resp_okay);
    wr(ctrl_off, 32'h2, resp_okay);
    see("rts", rts, 1'b0);
    $display("test rts commands done");
    wr(mode_off, 32'h9, resp_okay);
    @(posedge clk);
    full <= 1'b1;
    see("rts", rts, 1'b1);
    rdc("buffer state", dmab_off, 32'h3, resp_okay);
    see("irq", irq, 1'b0);
    wr(mask_off, 32'h4, resp_okay);
    see("irq", irq, 1'b1);
    wr(stat_off, 32'h4, resp_okay);
    see("irq", irq, 1'b0);
    @(posedge clk);
    full <= 1'b0;
    wr(ctrl_off, 32'h2, resp_okay);
    see("rts", rts, 1'b0);
    $display("test handshake done");
    wr(mode_off, 32'ha, resp_okay);
    wr(stat_off, 32'h7, resp_okay);
    peer_u.send(16'h00a5, 8);
    rdc("status", stat_off, 32'h1, resp_okay);
    rdc("received", rxd_off, 32'ha5, resp_okay);
    wr(stat_off, 32'h7, resp_okay);
    peer_u.send(16'h014b, 9);
    rdc("status", stat_off, 32'h2, resp_okay);
    $display("test overlength done");
    wr(ctrl_off, 32'h1, resp_okay);
    wr(mode_off, 32'hc, resp_okay);
    wr(stat_off, 32'h7, resp_okay);
    peer_u.send(16'h003c, 8);
    rdc("status", stat_off, 32'h1, resp_okay);
    wr(stat_off, 32'h7, resp_okay);
    peer_u.send(16'h00c3, 8);
    rdc("status", stat_off, 32'h0, resp_okay);
    wr(ctrl_off, 32'h1, resp_okay);
    wr(mode_off, 32'hc, resp_okay);
    peer_u.send(16'h005a, 8);
    rdc("status", stat_off, 32'h1, resp_okay);
    rdc("received", rxd_off, 32'h5a, resp_okay);
    rdc("unmapped", 8'h40, 32'h0, resp_slverr);
    wr(8'h40, 32'h0, resp_slverr);
    $display("test receive recovery done");
    summarize();
  end
endmodule // testbench
`default_nettype wire
